// ==== core/lad_top.sv ====
/*
 receive line alarm detector for one link, t1/j1 and e1 modes, with
 an ahb-lite register slave and one interrupt level.
 assumes framer strobes are synchronous to hclk; single word transfers.
*/
`timescale 1ns/100ps
module lad_top #(
   parameter int unsigned WIN_CYCLES = lad_pkg::T1_WIN_CYC,
   parameter int unsigned RED_E1_CYCLES = lad_pkg::E1_RED_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   input wire lad_pkg::lad_rx_t rx,
   output logic irq,
   output logic int_n
);
   import lad_pkg::*;

   localparam logic [TCW-1:0] WIN_LAST = TCW'(WIN_CYCLES - 1);
   localparam logic [TCW-1:0] RED_LAST = TCW'(RED_E1_CYCLES - 1);

   // ahb-lite slave: writes zero wait, reads one wait state
   logic aph_q, aph_d, wr_q, wr_d, rwait_q, rwait_d, rd_load, wr_en;
   logic [9:0] idx_q, idx_d;
   logic [31:0] rdata_q, rdata_d;
   logic [7:0] rd_val;

   always_comb
   begin
      rd_load = aph_q & ~wr_q & ~rwait_q;
      hreadyout = ~rd_load;
      wr_en = aph_q & wr_q;
      aph_d = aph_q;
      wr_d = wr_q;
      idx_d = idx_q;
      rwait_d = 1'b0;
      rdata_d = rdata_q;
      if (rd_load)
      begin
         rdata_d = {24'h000000, rd_val};
         rwait_d = 1'b1;
      end
      if (hreadyout)
      begin
         aph_d = hsel & htrans[1] & hready;
         wr_d = hwrite;
         idx_d = haddr[11:2];
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         aph_q <= 1'b0;
         wr_q <= 1'b0;
         idx_q <= 10'h000;
         rwait_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         aph_q <= aph_d;
         wr_q <= wr_d;
         idx_q <= idx_d;
         rwait_q <= rwait_d;
         rdata_q <= rdata_d;
      end
   end

   assign hrdata = rdata_q;
   assign hresp = 1'b0;

   // software registers
   logic [7:0] en_q, en_d, w1c;
   logic [7:0] thr_q [6];
   logic [7:0] thr_d [6];
   logic [1:0] crit_q, crit_d;
   logic [3:0] mode_q, mode_d;
   logic [7:0] status, flags;
   logic e1;
   lad_fmt_t fmt;

   assign e1 = mode_q[MODE_E1];
   assign fmt = lad_fmt_t'(mode_q[3:1]);

   always_comb
   begin
      en_d = en_q;
      thr_d = thr_q;
      crit_d = crit_q;
      mode_d = mode_q;
      w1c = 8'h00;
      if (wr_en)
      begin
         case (idx_q)
            IDX_EN: en_d = hwdata[7:0];
            IDX_CHG: w1c = hwdata[7:0];
            IDX_RED_DECL:
               if (e1)
                  crit_d = hwdata[1:0];
               else
                  thr_d[T_RED_D] = hwdata[7:0];
            IDX_RED_CLR: thr_d[T_RED_C] = hwdata[7:0];
            IDX_YEL_DECL: thr_d[T_YEL_D] = hwdata[7:0];
            IDX_YEL_CLR: thr_d[T_YEL_C] = hwdata[7:0];
            IDX_AIS_DECL: thr_d[T_AIS_D] = hwdata[7:0];
            IDX_AIS_CLR: thr_d[T_AIS_C] = hwdata[7:0];
            IDX_MODE: mode_d = hwdata[3:0];
            default: ;
         endcase
      end
      rd_val = 8'h00;
      case (idx_q)
         IDX_STATE: rd_val = status;
         IDX_EN: rd_val = en_q;
         IDX_CHG: rd_val = flags;
         IDX_RED_DECL: rd_val = e1 ? {6'h00, crit_q} : thr_q[T_RED_D];
         IDX_RED_CLR: rd_val = thr_q[T_RED_C];
         IDX_YEL_DECL: rd_val = thr_q[T_YEL_D];
         IDX_YEL_CLR: rd_val = thr_q[T_YEL_C];
         IDX_AIS_DECL: rd_val = thr_q[T_AIS_D];
         IDX_AIS_CLR: rd_val = thr_q[T_AIS_C];
         IDX_MODE: rd_val = {4'h0, mode_q};
         default: ;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         en_q <= EN_RST;
         thr_q <= '{default: THR_RST};
         crit_q <= CRIT_RST;
         mode_q <= MODE_RST;
      end
      else
      begin
         en_q <= en_d;
         thr_q <= thr_d;
         crit_q <= crit_d;
         mode_q <= mode_d;
      end
   end

   // t1/j1 fixed 40 ms windows
   logic [TCW-1:0] wcnt_q, wcnt_d;
   logic [7:0] ev_q, ev_d, ev_n, zer_q, zer_d, zer_n;
   logic [15:0] dl_q, dl_d;
   logic seen_q, seen_d, seen_n, win_end, ev_hit;
   logic red_bad, yel_bad, ais_bad, red_t1, yel_t1, ais_t1;

   always_comb
   begin
      win_end = (wcnt_q == WIN_LAST);
      wcnt_d = win_end ? '0 : wcnt_q + 1'b1;
      dl_d = rx.dl_vld ? {dl_q[14:0], rx.dl_val} : dl_q;
      case (fmt)
         FMT_SLC96: ev_hit = rx.slc_vld & rx.slc_val;
         FMT_T1_ESF: ev_hit = rx.dl_vld & ({dl_q[14:0], rx.dl_val} == ESF_PAT);
         FMT_T1_DM: ev_hit = rx.dm_vld & rx.dm_val;
         FMT_J1_SF: ev_hit = rx.fj_vld & ~rx.fj_val;
         FMT_J1_ESF: ev_hit = rx.dl_vld & ~rx.dl_val;
         default: ev_hit = 1'b0;
      endcase
      ev_n = (ev_hit && ev_q != 8'hff) ? ev_q + 8'h01 : ev_q;
      zer_n = (rx.bit_vld && !rx.bit_val && zer_q != 8'hff) ? zer_q + 8'h01 : zer_q;
      seen_n = seen_q | rx.sync;
      red_bad = ~seen_n;
      ais_bad = zer_n < T1_AIS_MIN_ZEROS;
      case (fmt)
         FMT_SLC96: yel_bad = ev_n < SLC_MIN_ONES;
         FMT_T1_ESF: yel_bad = ev_n > ESF_MAX_PAT;
         FMT_T1_DM: yel_bad = ev_n < DM_MIN_ONES;
         FMT_J1_SF: yel_bad = ev_n < J1SF_MIN_ZEROS;
         FMT_J1_ESF: yel_bad = ev_n < J1ESF_MIN_ZEROS;
         default: yel_bad = 1'b0;
      endcase
      ev_d = win_end ? 8'h00 : ev_n;
      zer_d = win_end ? 8'h00 : zer_n;
      seen_d = win_end ? 1'b0 : seen_n;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wcnt_q <= '0;
         ev_q <= 8'h00;
         zer_q <= 8'h00;
         dl_q <= 16'h0000;
         seen_q <= 1'b0;
      end
      else
      begin
         wcnt_q <= wcnt_d;
         ev_q <= ev_d;
         zer_q <= zer_d;
         dl_q <= dl_d;
         seen_q <= seen_d;
      end
   end

   lad_persist u_red (.clk(hclk), .rst_n(hresetn), .hold(e1), .win_end(win_end), .bad(red_bad),
      .decl_n(thr_q[T_RED_D]), .clr_n(thr_q[T_RED_C]), .state(red_t1));
   lad_persist u_yel (.clk(hclk), .rst_n(hresetn), .hold(e1), .win_end(win_end), .bad(yel_bad),
      .decl_n(thr_q[T_YEL_D]), .clr_n(thr_q[T_YEL_C]), .state(yel_t1));
   lad_persist u_ais (.clk(hclk), .rst_n(hresetn), .hold(e1), .win_end(win_end), .bad(ais_bad),
      .decl_n(thr_q[T_AIS_D]), .clr_n(thr_q[T_AIS_C]), .state(ais_t1));

   // e1 alarms
   logic [2:0] rai_run_q, rai_run_d, rmai_run_q, rmai_run_d;
   logic rai_q, rai_d, rmai_q, rmai_d, red_e1_q, red_e1_d, ais_e1_q, ais_e1_d;
   logic [TCW-1:0] rcnt_q, rcnt_d;
   logic [8:0] bcnt_q, bcnt_d;
   logic [1:0] az_q, az_d;
   logic alow_q, alow_d, low, tlow;
   logic [3:0] fcnt_q, fcnt_d, tsum;
   logic [2:0] tz_q, tz_d, tz_n;
   logic tlow_q, tlow_d, tsais_q, tsais_d, tslos_q, tslos_d;
   logic [4:0] zrun_q, zrun_d, nrun_q, nrun_d;

   always_comb
   begin
      rai_run_d = rai_run_q;
      rai_d = rai_q;
      rmai_run_d = rmai_run_q;
      rmai_d = rmai_q;
      rcnt_d = '0;
      red_e1_d = red_e1_q;
      bcnt_d = bcnt_q;
      az_d = az_q;
      alow_d = alow_q;
      ais_e1_d = ais_e1_q;
      fcnt_d = fcnt_q;
      tz_d = tz_q;
      tlow_d = tlow_q;
      tsais_d = tsais_q;
      zrun_d = zrun_q;
      nrun_d = nrun_q;
      tslos_d = tslos_q;
      tsum = {1'b0, tz_q} + 4'($countones(~rx.ts_oct));
      tz_n = (tsum > {1'b0, TS16_MIN_ZEROS}) ? TS16_MIN_ZEROS : tsum[2:0];
      low = 1'b0;
      tlow = tz_n < TS16_MIN_ZEROS;
      if (rx.sync && rx.a_vld)
      begin
         if (rx.a_val)
         begin
            rai_run_d = (rai_run_q == RAI_RUN) ? rai_run_q : rai_run_q + 3'h1;
            if (crit_q[CRIT_RAI] || rai_run_d == RAI_RUN)
               rai_d = 1'b1;
         end
         else
         begin
            rai_run_d = 3'h0;
            rai_d = 1'b0;
         end
      end
      if (rx.mf_sync && rx.y_vld)
      begin
         if (rx.y_val)
         begin
            rmai_run_d = (rmai_run_q == RMAI_RUN) ? rmai_run_q : rmai_run_q + 3'h1;
            if (rmai_run_d == RMAI_RUN)
               rmai_d = 1'b1;
         end
         else
         begin
            rmai_run_d = 3'h0;
            rmai_d = 1'b0;
         end
      end
      // count while sync disagrees with the alarm state
      if (rx.sync == red_e1_q)
      begin
         rcnt_d = rcnt_q + 1'b1;
         if (rcnt_q == RED_LAST)
         begin
            red_e1_d = ~red_e1_q;
            rcnt_d = '0;
         end
      end
      if (rx.bit_vld)
      begin
         az_d = (!rx.bit_val && az_q != E1_AIS_MIN_ZEROS) ? az_q + 2'h1 : az_q;
         bcnt_d = bcnt_q + 9'h001;
         if (bcnt_q == E1_AIS_LAST)
         begin
            low = az_d < E1_AIS_MIN_ZEROS;
            if (!crit_q[CRIT_AIS])
            begin
               if (low && !rx.sync)
                  ais_e1_d = 1'b1;
               else if (!low)
                  ais_e1_d = 1'b0;
            end
            else
            begin
               if (low && alow_q)
                  ais_e1_d = 1'b1;
               else if (!low && !alow_q)
                  ais_e1_d = 1'b0;
            end
            alow_d = low;
            az_d = 2'h0;
         end
      end
      if (!rx.sync)
      begin
         fcnt_d = 4'h0;
         tz_d = 3'h0;
         zrun_d = 5'h00;
         nrun_d = 5'h00;
      end
      else if (rx.ts_vld)
      begin
         tz_d = tz_n;
         fcnt_d = fcnt_q + 4'h1;
         if (fcnt_q == TS16_LAST)
         begin
            if (tlow && tlow_q)
               tsais_d = 1'b1;
            else if (!tlow)
               tsais_d = 1'b0;
            tlow_d = tlow;
            tz_d = 3'h0;
         end
         if (rx.ts_oct == 8'h00)
         begin
            zrun_d = (zrun_q == TS16_LOS_RUN) ? zrun_q : zrun_q + 5'h01;
            nrun_d = 5'h00;
         end
         else
         begin
            nrun_d = (nrun_q == TS16_LOS_RUN) ? nrun_q : nrun_q + 5'h01;
            zrun_d = 5'h00;
         end
         if (zrun_d == TS16_LOS_RUN)
            tslos_d = 1'b1;
         else if (nrun_d == TS16_LOS_RUN)
            tslos_d = 1'b0;
      end
      if (!e1)
      begin
         rai_d = 1'b0;
         rmai_d = 1'b0;
         red_e1_d = 1'b0;
         ais_e1_d = 1'b0;
         tsais_d = 1'b0;
         tslos_d = 1'b0;
         rcnt_d = '0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         rai_run_q <= 3'h0;
         rai_q <= 1'b0;
         rmai_run_q <= 3'h0;
         rmai_q <= 1'b0;
         rcnt_q <= '0;
         red_e1_q <= 1'b0;
         bcnt_q <= 9'h000;
         az_q <= 2'h0;
         alow_q <= 1'b0;
         ais_e1_q <= 1'b0;
         fcnt_q <= 4'h0;
         tz_q <= 3'h0;
         tlow_q <= 1'b0;
         tsais_q <= 1'b0;
         zrun_q <= 5'h00;
         nrun_q <= 5'h00;
         tslos_q <= 1'b0;
      end
      else
      begin
         rai_run_q <= rai_run_d;
         rai_q <= rai_d;
         rmai_run_q <= rmai_run_d;
         rmai_q <= rmai_d;
         rcnt_q <= rcnt_d;
         red_e1_q <= red_e1_d;
         bcnt_q <= bcnt_d;
         az_q <= az_d;
         alow_q <= alow_d;
         ais_e1_q <= ais_e1_d;
         fcnt_q <= fcnt_d;
         tz_q <= tz_d;
         tlow_q <= tlow_d;
         tsais_q <= tsais_d;
         zrun_q <= zrun_d;
         nrun_q <= nrun_d;
         tslos_q <= tslos_d;
      end
   end

   always_comb
   begin
      status = 8'h00;
      status[B_RED] = e1 ? red_e1_q : red_t1;
      status[B_AIS] = e1 ? ais_e1_q : ais_t1;
      status[B_YEL] = ~e1 & yel_t1;
      status[B_RAI] = rai_q;
      status[B_RMAI] = rmai_q;
      status[B_TSAIS] = tsais_q;
      status[B_TSLOS] = tslos_q;
   end

   lad_change_flags u_flags (.clk(hclk), .rst_n(hresetn), .status(status), .clr(w1c), .en(en_q),
      .flags(flags), .irq(irq));
   assign int_n = ~irq;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence a_one;
      e1 && rx.sync && rx.a_vld && rx.a_val;
   endsequence
   sequence y_one;
      e1 && rx.mf_sync && rx.y_vld && rx.y_val;
   endsequence

   flag_on_edge_a: assert property ($changed(status) |=> &(flags | ~($past(status) ^ $past(status, 2))))
      else $error("change flag not set on status edge");
   irq_mask_a: assert property (irq == |(flags & $past(en_q)))
      else $error("interrupt level disagrees with flags and enables");
   t1_red_win_a: assert property ($rose(status[B_RED]) && !e1 |-> $past(win_end))
      else $error("t1 carrier fail changed off a window edge");
   rai_fast_a: assert property (a_one and crit_q[CRIT_RAI] |=> rai_q)
      else $error("single-bit remote alarm not declared");
   rai_four_a: assert property (a_one and !crit_q[CRIT_RAI] && rai_run_q < 3'h3 && !rai_q |=> !rai_q)
      else $error("remote alarm declared too early");
   rai_clear_a: assert property (e1 && rx.sync && rx.a_vld && !rx.a_val |=> !rai_q)
      else $error("remote alarm not cleared on zero");
   rmai_decl_a: assert property (y_one and rmai_run_q == 3'h2 |=> rmai_q)
      else $error("multiframe alarm not declared after three ones");
   e1_red_sync_a: assert property (e1 && !red_e1_q && rx.sync |=> !red_e1_q)
      else $error("e1 carrier fail declared while in sync");
   ais_e1_sync_a: assert property (e1 && !crit_q[CRIT_AIS] && !ais_e1_q && rx.sync |=> !ais_e1_q)
      else $error("e1 all-ones declared while in sync");
   tsais_frame_a: assert property ($fell(tsais_q) && $past(e1) |-> $past(fcnt_q) == TS16_LAST)
      else $error("slot 16 all-ones cleared off a period edge");
   los_decl_a: assert property (e1 && rx.sync && rx.ts_vld && rx.ts_oct == 8'h00 && zrun_q == 5'h0f |=> tslos_q)
      else $error("slot 16 loss not declared after sixteen zero octets");
endmodule

// ==== pkg/lad_pkg.sv ====
/*
 package of the line alarm detector: register indices, field positions,
 reset values, detection limits and timing counts.
 assumes a 200 MHz core clock; the framer feeds one struct per cycle.
*/
package lad_pkg;
   localparam int CLK_MHZ = 200;
   localparam int T1_WIN_MS = 40;
   localparam int E1_RED_MS = 100;
   localparam int T1_WIN_CYC = T1_WIN_MS * CLK_MHZ * 1000;
   localparam int E1_RED_CYC = E1_RED_MS * CLK_MHZ * 1000;
   localparam int TCW = 25;

   // register index; byte address is four times the index
   localparam logic [9:0] IDX_STATE = 10'h0b9;
   localparam logic [9:0] IDX_EN = 10'h0ba;
   localparam logic [9:0] IDX_CHG = 10'h0bb;
   localparam logic [9:0] IDX_RED_DECL = 10'h0bc;
   localparam logic [9:0] IDX_CRIT = 10'h0bc;
   localparam logic [9:0] IDX_RED_CLR = 10'h0bd;
   localparam logic [9:0] IDX_YEL_DECL = 10'h0be;
   localparam logic [9:0] IDX_YEL_CLR = 10'h0bf;
   localparam logic [9:0] IDX_AIS_DECL = 10'h0c0;
   localparam logic [9:0] IDX_AIS_CLR = 10'h0c1;
   localparam logic [9:0] IDX_MODE = 10'h0c7;

   // threshold array slots
   localparam int T_RED_D = 0;
   localparam int T_RED_C = 1;
   localparam int T_YEL_D = 2;
   localparam int T_YEL_C = 3;
   localparam int T_AIS_D = 4;
   localparam int T_AIS_C = 5;

   // status, enable and change-flag bit positions
   localparam int B_RED = 0;
   localparam int B_AIS = 1;
   localparam int B_YEL = 2;
   localparam int B_RAI = 3;
   localparam int B_RMAI = 4;
   localparam int B_TSAIS = 5;
   localparam int B_TSLOS = 6;

   localparam int MODE_E1 = 0;
   localparam int CRIT_RAI = 0;
   localparam int CRIT_AIS = 1;

   localparam logic [7:0] THR_RST = 8'h00;
   localparam logic [7:0] EN_RST = 8'h00;
   localparam logic [1:0] CRIT_RST = 2'h0;
   localparam logic [3:0] MODE_RST = 4'h0;

   localparam logic [7:0] SLC_MIN_ONES = 8'h4d;
   localparam logic [7:0] ESF_MAX_PAT = 8'h07;
   localparam logic [15:0] ESF_PAT = 16'hff00;
   localparam logic [7:0] DM_MIN_ONES = 8'h04;
   localparam logic [7:0] J1SF_MIN_ZEROS = 8'h04;
   localparam logic [7:0] J1ESF_MIN_ZEROS = 8'h03;
   localparam logic [7:0] T1_AIS_MIN_ZEROS = 8'h3d;
   localparam logic [8:0] E1_AIS_LAST = 9'h1ff;
   localparam logic [1:0] E1_AIS_MIN_ZEROS = 2'h3;
   localparam logic [2:0] RAI_RUN = 3'h4;
   localparam logic [2:0] RMAI_RUN = 3'h3;
   localparam logic [3:0] TS16_LAST = 4'hf;
   localparam logic [2:0] TS16_MIN_ZEROS = 3'h4;
   localparam logic [4:0] TS16_LOS_RUN = 5'h10;

   typedef enum logic [2:0] {FMT_T1_SF, FMT_T1_ESF, FMT_T1_DM, FMT_SLC96, FMT_J1_SF, FMT_J1_ESF} lad_fmt_t;

   // one cycle of framer output; *_vld marks a valid strobe for that bit
   typedef struct packed {
      logic sync;
      logic mf_sync;
      logic bit_vld;
      logic bit_val;
      logic a_vld;
      logic a_val;
      logic y_vld;
      logic y_val;
      logic dl_vld;
      logic dl_val;
      logic slc_vld;
      logic slc_val;
      logic dm_vld;
      logic dm_val;
      logic fj_vld;
      logic fj_val;
      logic ts_vld;
      logic [7:0] ts_oct;
   } lad_rx_t;
endpackage

// ==== core/lad_persist.sv ====
/*
 window persistence filter: unless hold clears it, moves its state only after the opposite
 condition holds for a programmed number of consecutive windows.
 assumes win_end pulses once per window; a limit of zero acts as one.
*/
`timescale 1ns/100ps
module lad_persist (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hold,
   input wire logic win_end,
   input wire logic bad,
   input wire logic [7:0] decl_n,
   input wire logic [7:0] clr_n,
   output logic state
);
   logic [7:0] cnt_q, cnt_d, need, run;
   logic st_q, st_d;

   always_comb
   begin
      need = st_q ? clr_n : decl_n;
      if (need == 8'h00)
         need = 8'h01;
      run = cnt_q + 8'h01;
      cnt_d = cnt_q;
      st_d = st_q;
      if (hold)
      begin
         cnt_d = 8'h00;
         st_d = 1'b0;
      end
      else if (win_end)
      begin
         if (bad != st_q)
         begin
            if (run >= need)
            begin
               st_d = bad;
               cnt_d = 8'h00;
            end
            else
               cnt_d = run;
         end
         else
            cnt_d = 8'h00;
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q <= 8'h00;
         st_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         st_q <= st_d;
      end
   end

   assign state = st_q;
endmodule

// ==== core/lad_change_flags.sv ====
/*
 sticky change flags: any edge on a status bit sets its flag, a one
 written clears it, enabled flags drive the interrupt level.
 assumes clr is a one-cycle write pulse from the bus slave.
*/
`timescale 1ns/100ps
module lad_change_flags (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] status,
   input wire logic [7:0] clr,
   input wire logic [7:0] en,
   output logic [7:0] flags,
   output logic irq
);
   logic [7:0] prev_q, flg_q, flg_d;
   logic irq_q, irq_d;

   always_comb
   begin
      // a new edge wins over a clear in the same cycle
      flg_d = (flg_q & ~clr) | (status ^ prev_q);
      irq_d = |(flg_d & en);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prev_q <= 8'h00;
         flg_q <= 8'h00;
         irq_q <= 1'b0;
      end
      else
      begin
         prev_q <= status;
         flg_q <= flg_d;
         irq_q <= irq_d;
      end
   end

   assign flags = flg_q;
   assign irq = irq_q;
endmodule

// ==== test/lad_framer.sv ====
/*
 framer model: level sync inputs, one strobe at a time on the A or Y bit,
 optional line and channel 24 bits and one slot 16 octet every cycle.
 assumes the bench sets the level controls and calls send.
*/
`timescale 1ns/100ps
module lad_framer (
   input wire logic clk,
   output lad_pkg::lad_rx_t rx
);
   import lad_pkg::*;
   logic sync_lvl = 1'b1;
   logic mf_lvl = 1'b0;
   logic p = 1'b0;
   logic k = 1'b0;
   logic v = 1'b0;
   logic bits_on = 1'b0;
   logic bit_lvl = 1'b0;
   logic ts_on = 1'b0;
   logic [7:0] oct = 8'h00;
   lad_rx_t r = '0;
   assign rx = r;
   // kind 0 is an A bit, kind 1 a Y bit
   task automatic send(input logic kind, input logic val);
      @(posedge clk);
      p <= 1'b1;
      k <= kind;
      v <= val;
      @(posedge clk);
      p <= 1'b0;
   endtask
   // idle A and Y value lines toggle so a stale bit never reads as data
   always @(posedge clk)
   begin
      r.sync <= sync_lvl;
      r.mf_sync <= mf_lvl;
      r.a_vld <= p & ~k;
      r.y_vld <= p & k;
      r.a_val <= p ? v : ~r.a_val;
      r.y_val <= p ? v : ~r.y_val;
      r.bit_vld <= bits_on;
      r.bit_val <= bit_lvl;
      r.dm_vld <= bits_on;
      r.dm_val <= bit_lvl;
      r.ts_vld <= ts_on;
      r.ts_oct <= oct;
   end
endmodule

// ==== test/lad_top_tb.sv ====
/*
 bench of the line alarm detector: ahb-lite tasks and alarm scenarios.
 assumes the framer model lad_framer on the rx port.
*/
`timescale 1ns/100ps
module lad_top_tb;
   import lad_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic [31:0] hrdata;
   logic hresp;
   logic irq;
   logic int_n;
   lad_rx_t rx;
   logic [31:0] rd;
   int err_total = 0;
   int n_compared = 0;
   lad_top #(.WIN_CYCLES(64), .RED_E1_CYCLES(50)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .rx(rx), .irq(irq), .int_n(int_n));
   lad_framer fw (.clk(hclk), .rx(rx));
   task automatic complete_run;
      if (err_total == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, idx, 2'h0};
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rd, exp);
      chk({31'h0, hresp}, 32'h0);
   endtask
   task automatic t_regs;
      rchk(IDX_EN, 32'h0);
      bus(1'b1, IDX_EN, 8'h7f);
      rchk(IDX_EN, 32'h7f);
      bus(1'b1, 10'h0c8, 8'hff);
      rchk(10'h0c8, 32'h0);
      bus(1'b1, IDX_STATE, 8'hff);
      repeat (200) @(posedge hclk);
      rchk(IDX_STATE, 32'h2);
      rchk(IDX_CHG, 32'h2);
      chk({30'h0, irq, int_n}, 32'h2);
      bus(1'b1, IDX_EN, 8'h00);
      rchk(IDX_EN, 32'h0);
      chk({30'h0, irq, int_n}, 32'h1);
   endtask
   task automatic t_t1;
      bus(1'b1, IDX_MODE, 8'h04);
      bus(1'b1, IDX_RED_DECL, 8'h02);
      bus(1'b1, IDX_RED_CLR, 8'h02);
      fw.sync_lvl <= 1'b0;
      repeat (250) @(posedge hclk);
      rchk(IDX_STATE, 32'h7);
      fw.sync_lvl <= 1'b1;
      fw.bits_on <= 1'b1;
      repeat (250) @(posedge hclk);
      rchk(IDX_STATE, 32'h4);
      fw.bit_lvl <= 1'b1;
      repeat (250) @(posedge hclk);
      rchk(IDX_STATE, 32'h2);
      fw.bits_on <= 1'b0;
   endtask
   task automatic t_e1_red;
      bus(1'b1, IDX_MODE, 8'h01);
      fw.sync_lvl <= 1'b0;
      repeat (100) @(posedge hclk);
      rchk(IDX_STATE, 32'h1);
      fw.sync_lvl <= 1'b1;
      repeat (100) @(posedge hclk);
      rchk(IDX_STATE, 32'h0);
      bus(1'b1, IDX_CHG, 8'hff);
      rchk(IDX_CHG, 32'h0);
   endtask
   task automatic t_rai;
      bus(1'b1, IDX_EN, 8'h08);
      repeat (3) fw.send(1'b0, 1'b1);
      rchk(IDX_STATE, 32'h0);
      fw.send(1'b0, 1'b1);
      rchk(IDX_STATE, 32'h8);
      chk({30'h0, irq, int_n}, 32'h2);
      fw.send(1'b0, 1'b0);
      rchk(IDX_STATE, 32'h0);
      bus(1'b1, IDX_CHG, 8'h08);
      rchk(IDX_CHG, 32'h0);
      chk({30'h0, irq, int_n}, 32'h1);
      bus(1'b1, IDX_CRIT, 8'h01);
      fw.send(1'b0, 1'b1);
      rchk(IDX_STATE, 32'h8);
      fw.send(1'b0, 1'b0);
      rchk(IDX_STATE, 32'h0);
   endtask
   task automatic t_rmai;
      fw.mf_lvl <= 1'b1;
      repeat (2) fw.send(1'b1, 1'b1);
      rchk(IDX_STATE, 32'h0);
      fw.send(1'b1, 1'b1);
      rchk(IDX_STATE, 32'h10);
      fw.send(1'b1, 1'b0);
      rchk(IDX_STATE, 32'h0);
   endtask
   task automatic t_e1_ais;
      fw.bit_lvl <= 1'b1;
      fw.bits_on <= 1'b1;
      fw.sync_lvl <= 1'b0;
      repeat (1700) @(posedge hclk);
      rchk(IDX_STATE, 32'h3);
      fw.bit_lvl <= 1'b0;
      repeat (1700) @(posedge hclk);
      rchk(IDX_STATE, 32'h1);
      fw.sync_lvl <= 1'b1;
      fw.bit_lvl <= 1'b1;
      bus(1'b1, IDX_CRIT, 8'h02);
      repeat (1700) @(posedge hclk);
      rchk(IDX_STATE, 32'h2);
      fw.bit_lvl <= 1'b0;
      repeat (1700) @(posedge hclk);
      rchk(IDX_STATE, 32'h0);
      fw.bits_on <= 1'b0;
      bus(1'b1, IDX_CHG, 8'hff);
   endtask
   task automatic t_ts16;
      fw.ts_on <= 1'b1;
      fw.oct <= 8'h00;
      repeat (60) @(posedge hclk);
      rchk(IDX_STATE, 32'h40);
      fw.oct <= 8'hff;
      repeat (60) @(posedge hclk);
      rchk(IDX_STATE, 32'h20);
      fw.oct <= 8'h0f;
      repeat (60) @(posedge hclk);
      rchk(IDX_STATE, 32'h0);
   endtask
   initial
   begin
      forever #2.5 hclk = ~hclk;
   end
   initial
   begin
      #200000;
      err_total++;
      complete_run;
   end
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_t1;
      t_e1_red;
      t_e1_ais;
      t_rai;
      t_rmai;
      t_ts16;
      complete_run;
   end
endmodule
